// ---- rtl/dqe_pkg.sv ----
package dqe_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] QES_LO_OFS   = 8'h00;
  localparam logic [7:0] QES_HI_OFS   = 8'h04;
  localparam logic [7:0] QFC_LO_OFS   = 8'h08;
  localparam logic [7:0] QFC_HI_OFS   = 8'h0c;
  localparam logic [7:0] IEN_LO_OFS   = 8'h10;
  localparam logic [7:0] IEN_HI_OFS   = 8'h14;
  localparam logic [7:0] IES_LO_OFS   = 8'h18;
  localparam logic [7:0] IES_HI_OFS   = 8'h1c;
  localparam logic [7:0] IED_LO_OFS   = 8'h20;
  localparam logic [7:0] IED_HI_OFS   = 8'h24;
  localparam logic [7:0] IST_LO_OFS   = 8'h28;
  localparam logic [7:0] IST_HI_OFS   = 8'h2c;
  localparam logic [7:0] IMSK_LO_OFS  = 8'h30;
  localparam logic [7:0] IMSK_HI_OFS  = 8'h34;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam int          NCH        = 64;
  localparam logic [63:0] BITS_RST   = 64'h0;
  localparam logic [31:0] RD_ZERO    = 32'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // event from the prioritiser side
  typedef struct packed {
    logic       valid;
    logic [5:0] chan;
  } dqe_evt_t;

  // queue retire report: null requests leave the flag for software
  typedef struct packed {
    logic       valid;
    logic [5:0] chan;
    logic       is_null;
  } dqe_retire_t;

endpackage : dqe_pkg

// ---- rtl/dqe_bank.sv ----
`timescale 1ns/1ps

module dqe_bank
  import dqe_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address / data / response
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // queue side
  input  wire dqe_pkg::dqe_evt_t    trig_evt,
  output logic                      trig_accept,
  input  wire dqe_pkg::dqe_retire_t retire_evt,
  input  wire dqe_pkg::dqe_evt_t    done_code,
  output logic [63:0]               queued_event_status,
  output logic [63:0]               irq_enable,
  // interrupt
  output logic                   irq
);
  import dqe_pkg::*;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic        aw_have_r;
  logic        aw_have_nxt;
  logic        w_have_r;
  logic        w_have_nxt;
  logic [7:0]  aw_addr_r;
  logic [7:0]  aw_addr_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0]  w_strb_r;
  logic [3:0]  w_strb_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] wmask;

  logic [63:0] qflag_r;
  logic [63:0] qflag_nxt;
  logic [63:0] ien_r;
  logic [63:0] ien_nxt;
  logic [63:0] ist_r;
  logic [63:0] ist_nxt;
  logic [63:0] imsk_r;
  logic [63:0] imsk_nxt;

  // one-cycle strobes from register writes and queue events, nothing held
  logic [63:0] qclr_w;
  logic [63:0] iset_w;
  logic [63:0] idrop_w;
  logic [63:0] ist_clr_w;
  logic [63:0] retire_clr;
  logic [63:0] trig_set;
  logic [63:0] done_set;
  logic [63:0] imsk_wr_lo;
  logic [63:0] imsk_wr_hi;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  // one read in flight, no skid buffer behind arready
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  // no write acts while a response still waits
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= RD_ZERO;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // queued-event status and enable words are not writable
  always_comb begin
    qclr_w     = BITS_RST;
    iset_w     = BITS_RST;
    idrop_w    = BITS_RST;
    ist_clr_w  = BITS_RST;
    imsk_wr_lo = BITS_RST;
    imsk_wr_hi = BITS_RST;
    wr_hit     = 1'b1;
    if (wr_fire) begin
      case ({aw_addr_r[7:2], 2'b00})
        QFC_LO_OFS:  qclr_w[31:0]      = w_data_r & wmask;
        QFC_HI_OFS:  qclr_w[63:32]     = w_data_r & wmask;
        IES_LO_OFS:  iset_w[31:0]      = w_data_r & wmask;
        IES_HI_OFS:  iset_w[63:32]     = w_data_r & wmask;
        IED_LO_OFS:  idrop_w[31:0]     = w_data_r & wmask;
        IED_HI_OFS:  idrop_w[63:32]    = w_data_r & wmask;
        IST_LO_OFS:  ist_clr_w[31:0]   = w_data_r & wmask;
        IST_HI_OFS:  ist_clr_w[63:32]  = w_data_r & wmask;
        IMSK_LO_OFS: imsk_wr_lo[31:0]  = wmask;
        IMSK_HI_OFS: imsk_wr_hi[63:32] = wmask;
        QES_LO_OFS, QES_HI_OFS, IEN_LO_OFS, IEN_HI_OFS: wr_hit = 1'b1;
        default:     wr_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        QES_LO_OFS:  rdata_nxt = qflag_r[31:0];
        QES_HI_OFS:  rdata_nxt = qflag_r[63:32];
        IEN_LO_OFS:  rdata_nxt = ien_r[31:0];
        IEN_HI_OFS:  rdata_nxt = ien_r[63:32];
        IST_LO_OFS:  rdata_nxt = ist_r[31:0];
        IST_HI_OFS:  rdata_nxt = ist_r[63:32];
        IMSK_LO_OFS: rdata_nxt = imsk_r[31:0];
        IMSK_HI_OFS: rdata_nxt = imsk_r[63:32];
        QFC_LO_OFS, QFC_HI_OFS, IES_LO_OFS, IES_HI_OFS,
        IED_LO_OFS, IED_HI_OFS: rdata_nxt = RD_ZERO;
        default: begin
          rdata_nxt = RD_ZERO;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= RD_ZERO;
      rresp_r   <= RESP_OKAY;
    end else begin
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // queued flags, enables, completion status
  // ----------------------------------------------------------------
  // flagged channel refuses new events
  assign trig_accept = trig_evt.valid && !qflag_r[trig_evt.chan];

  always_comb begin
    trig_set   = BITS_RST;
    retire_clr = BITS_RST;
    done_set   = BITS_RST;
    if (trig_accept)
      trig_set[trig_evt.chan] = 1'b1;
    if (retire_evt.valid && !retire_evt.is_null)
      retire_clr[retire_evt.chan] = 1'b1;
    if (done_code.valid)
      done_set[done_code.chan] = 1'b1;
  end

  always_comb begin
    // held while queued; set wins over clear
    qflag_nxt = (qflag_r & ~qclr_w & ~retire_clr) | trig_set;
    // set wins over drop in same write cycle is moot: separate addresses
    ien_nxt   = (ien_r & ~idrop_w) | iset_w;
    ist_nxt   = (ist_r & ~ist_clr_w) | done_set;
    imsk_nxt  = (imsk_r & ~(imsk_wr_lo | imsk_wr_hi))
              | ({w_data_r, w_data_r} & (imsk_wr_lo | imsk_wr_hi));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qflag_r   <= BITS_RST;
      ien_r     <= BITS_RST;
      ist_r     <= BITS_RST;
      imsk_r    <= BITS_RST;
    end else begin
      qflag_r   <= qflag_nxt;
      ien_r     <= ien_nxt;
      ist_r     <= ist_nxt;
      imsk_r    <= imsk_nxt;
    end
  end

  assign queued_event_status = qflag_r;
  assign irq_enable          = ien_r;

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // enabled, unmasked pending raises irq
  assign irq = |(ist_r & imsk_r & ien_r);

endmodule : dqe_bank

// ---- test/dqe_queue_model.sv ----
`timescale 1ns/1ps
module dqe_queue_model
  import dqe_pkg::*;
(
  // clock
  input logic aclk,
  // queue side
  input logic trig_accept,
  output dqe_pkg::dqe_evt_t trig_evt,
  output dqe_pkg::dqe_retire_t retire_evt,
  output dqe_pkg::dqe_evt_t done_code
);
  // idle fields flip so a stale channel is never trusted
  initial begin
    trig_evt = 7'h3f;
    retire_evt = 8'h7e;
    done_code = 7'h3f;
  end
  task automatic trig(input logic [5:0] c, output logic a);
    trig_evt <= {1'b1, c};
    @(posedge aclk);
    a = trig_accept;
    trig_evt <= {1'b0, ~c};
    @(posedge aclk);
  endtask : trig
  task automatic retire(input logic [5:0] c, input logic n);
    retire_evt <= {1'b1, c, n};
    @(posedge aclk);
    retire_evt <= {1'b0, ~c, ~n};
    @(posedge aclk);
  endtask : retire
  task automatic done(input logic [5:0] c);
    done_code <= {1'b1, c};
    @(posedge aclk);
    done_code <= {1'b0, ~c};
    @(posedge aclk);
  endtask : done
endmodule : dqe_queue_model

// ---- test/dqe_chk.sv ----
`timescale 1ns/1ps
module dqe_chk
  import dqe_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // bus
  input logic s_axi_awvalid,
  input logic s_axi_wvalid,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [7:0] s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  // queue side
  input dqe_pkg::dqe_evt_t trig_evt,
  input logic trig_accept,
  input dqe_pkg::dqe_retire_t retire_evt,
  input logic [63:0] queued_event_status,
  input logic [63:0] irq_enable
);
  import dqe_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  accept_rule_a: assert property (
    trig_accept == (trig_evt.valid && !queued_event_status[trig_evt.chan])) else $error("accept mismatch");
  flag_set_a: assert property (
    trig_accept |=> queued_event_status[$past(trig_evt.chan)]) else $error("flag not set");
  null_keep_a: assert property (
    retire_evt.valid && retire_evt.is_null && queued_event_status[retire_evt.chan] && !s_axi_awvalid
    && !s_axi_wvalid |=> queued_event_status[$past(retire_evt.chan)]) else $error("null retire cleared");
  valid_clear_a: assert property (
    retire_evt.valid && !retire_evt.is_null && !trig_accept |=> !queued_event_status[$past(retire_evt.chan)])
    else $error("retire did not clear");
  flag_rise_a: assert property (
    |(queued_event_status & ~$past(queued_event_status)) |-> $past(trig_accept)) else $error("stray set");
  flag_drop_a: assert property (
    |(~queued_event_status & $past(queued_event_status)) |-> $past(retire_evt.valid) || $rose(s_axi_bvalid))
    else $error("stray clear");
  en_change_a: assert property (
    irq_enable != $past(irq_enable) |-> $rose(s_axi_bvalid)) else $error("enable changed alone");
  port_zero_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr inside {8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24}
    |=> s_axi_rdata == 32'h0) else $error("port read nonzero");
  cover property (trig_evt.valid && !trig_accept);
  cover property (retire_evt.valid && retire_evt.is_null);
  cover property (irq_enable != 64'h0);
endmodule : dqe_chk
bind dqe_bank dqe_chk dqe_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .trig_evt, .trig_accept, .retire_evt,
  .queued_event_status, .irq_enable);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import dqe_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trig_accept, irq, acc;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] queued_event_status, irq_enable;
  dqe_evt_t trig_evt, done_code;
  dqe_retire_t retire_evt;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #4 aclk = ~aclk;
  dqe_bank dqe_bank_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .trig_evt, .trig_accept, .retire_evt, .done_code, .queued_event_status, .irq_enable, .irq);
  dqe_queue_model dqe_queue_model_i (.aclk, .trig_accept, .trig_evt, .retire_evt, .done_code);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), a > 8'h34 ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // hang guard, the sequence needs under two hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0);
    wr(8'h18, 32'h8000_0001);
    wr(8'h1c, 32'h8000_0000);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h8000_0001);
    rd(8'h14, 32'h8000_0000);
    rd(8'h18, 32'h0);
    wr(8'h20, 32'h0000_0001);
    rd(8'h10, 32'h8000_0000);
    dqe_queue_model_i.trig(6'd33, acc);
    chk(32'(acc), 32'h1);
    dqe_queue_model_i.trig(6'd33, acc);
    chk(32'(acc), 32'h0);
    rd(8'h04, 32'h2);
    dqe_queue_model_i.retire(6'd33, 1'b1);
    rd(8'h04, 32'h2);
    wr(8'h0c, 32'h1);
    rd(8'h04, 32'h2);
    wr(8'h0c, 32'h2);
    rd(8'h04, 32'h0);
    dqe_queue_model_i.trig(6'd5, acc);
    rd(8'h00, 32'h20);
    dqe_queue_model_i.retire(6'd5, 1'b0);
    rd(8'h00, 32'h0);
    dqe_queue_model_i.done(6'd63);
    dqe_queue_model_i.done(6'd0);
    rd(8'h2c, 32'h8000_0000);
    rd(8'h28, 32'h1);
    wr(8'h30, 32'h1);
    chk(32'(irq), 32'h0);
    wr(8'h34, 32'h8000_0000);
    chk(32'(irq), 32'h1);
    wr(8'h2c, 32'h8000_0000);
    chk(32'(irq), 32'h0);
    rd(8'h3c, 32'h0);
    complete_run();
  end
endmodule : tb_top
